//--- src/umaf_pkg.sv
/*
 * Constants, types and states for the multiprocessor address filter receiver.
 * Assumes a single 200 MHz core clock and a synchronous active-high reset.
 */
package umaf_pkg;
    localparam int CLK_MHZ = 200;
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8 = 2'h3;
    localparam logic [5:0] DIV12_TOP = 6'h0B;
    localparam logic [5:0] DIV4_TOP = 6'h03;
    localparam logic [5:0] DIV48_TOP = 6'h2F;
    localparam logic [5:0] EXT8_TOP = 6'h07;
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [7:0] BROADCAST_ALL = 8'hFF;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } umaf_rxword_s;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_NINTH = 5'b01000,
        RX_STOP = 5'b10000
    } umaf_rxstate_e;
endpackage

//--- src/umaf_fifo.sv
/*
 * Synchronous FIFO with registered read data and valid/ready on both sides.
 * Assumes both sides run on the same clock.
 */
module umaf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic outValid_r;
    logic [WIDTH-1:0] outData_r;

    wire logic full = (count_r == (AW+1)'(DEPTH));
    wire logic empty = (count_r == '0);
    wire logic push = inValid && !full;
    wire logic pop = !empty && (!outValid_r || outReady);

    assign inReady = !full;
    assign outValid = outValid_r;
    assign outData = outData_r;

    // Storage carries no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            outValid_r <= 1'b0;
            outData_r <= '0;
        end else begin
            wrPtr_r <= push ? wrPtr_r + 1'b1 : wrPtr_r;
            rdPtr_r <= pop ? rdPtr_r + 1'b1 : rdPtr_r;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
            if (pop) begin
                outValid_r <= 1'b1;
                outData_r <= mem[rdPtr_r];
            end else if (outReady) begin
                outValid_r <= 1'b0;
            end
        end
    end
endmodule // umaf_fifo

//--- src/umaf_top.sv
/*
 * Receive side of the primary serial port with baud timer and address filter.
 * Assumes rxPin and ext_osc_clock are asynchronous pins; config ports are stable logic.
 */
module umaf_top
    import umaf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pins
    input wire logic rxPin,
    input wire logic extOscClock,
    // Configuration
    input wire logic nineBitMode,
    input wire logic multiprocAddrSelect,
    input wire logic [7:0] slaveAddressReg,
    input wire logic [7:0] slaveAddressMask,
    input wire logic [1:0] timer1PrescaleSel,
    input wire logic timer1DirectClockSel,
    input wire logic [7:0] timerReload,
    input wire logic overrunClear,
    // Status
    output logic rxNinthBit,
    output logic rxEvent,
    output logic rxOverrun,
    // Received words
    output logic rxValid,
    input wire logic rxReady,
    output umaf_rxword_s rxWord
);
    // Pin synchronisers
    logic rxMeta_r;
    logic rxSync_r;
    logic rxPrev_r;
    logic extMeta_r;
    logic extSync_r;
    logic extPrev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rxMeta_r <= 1'b1;
            rxSync_r <= 1'b1;
            rxPrev_r <= 1'b1;
            extMeta_r <= 1'b0;
            extSync_r <= 1'b0;
            extPrev_r <= 1'b0;
        end else begin
            rxMeta_r <= rxPin;
            rxSync_r <= rxMeta_r;
            rxPrev_r <= rxSync_r;
            extMeta_r <= extOscClock;
            extSync_r <= extMeta_r;
            extPrev_r <= extSync_r;
        end
    end

    wire logic extRise = extSync_r && !extPrev_r;
    wire logic rxFall = !rxSync_r && rxPrev_r;

    // Prescaler
    logic [5:0] preCnt_r;
    logic [5:0] preCnt_nxt;
    wire logic useExt = (timer1PrescaleSel == PRE_EXT8);
    wire logic preStep = useExt ? extRise : 1'b1;
    wire logic [5:0] preTop = (timer1PrescaleSel == PRE_DIV12) ? DIV12_TOP :
                              (timer1PrescaleSel == PRE_DIV4) ? DIV4_TOP :
                              (timer1PrescaleSel == PRE_DIV48) ? DIV48_TOP : EXT8_TOP;
    wire logic preWrap = preStep && (preCnt_r >= preTop);
    wire logic tmrTick = timer1DirectClockSel ? 1'b1 : preWrap;

    assign preCnt_nxt = preWrap ? 6'h00 : (preStep ? preCnt_r + 6'h01 : preCnt_r);

    always_ff @(posedge clk) begin
        if (srst) begin
            preCnt_r <= 6'h00;
        end else begin
            preCnt_r <= preCnt_nxt;
        end
    end

    // Auto-reload baud timer; each overflow is half a bit time
    logic [7:0] tmr_r;
    wire logic tmrOvf = tmrTick && (tmr_r == TIMER_TOP);

    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_r <= 8'h00;
        end else if (tmrTick) begin
            tmr_r <= tmrOvf ? timerReload : tmr_r + 8'h01;
        end
    end

    // Address decode
    wire logic [7:0] broadcastAddr = slaveAddressReg | slaveAddressMask;
    logic [7:0] shift_r;
    logic ninth_r;
    wire logic maskedHit = ((shift_r & slaveAddressMask) ==
                            (slaveAddressReg & slaveAddressMask));
    wire logic broadcastHit = ((shift_r & broadcastAddr) == broadcastAddr);
    wire logic addrHit = maskedHit || broadcastHit;
    wire logic filterOn = nineBitMode && multiprocAddrSelect;
    wire logic passFilter = !filterOn || (ninth_r && addrHit);

    // Receiver state machine
    umaf_rxstate_e state_r;
    umaf_rxstate_e state_nxt;
    logic half_r;
    logic [2:0] bitCnt_r;
    wire logic sampleNow = tmrOvf && half_r;
    wire logic stopSample = (state_r == RX_STOP) && sampleNow;
    wire logic acceptByte = stopSample && passFilter;
    wire logic fifoReady;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RX_IDLE: begin
                if (rxFall) begin
                    state_nxt = RX_START;
                end
            end
            RX_START: begin
                if (tmrOvf) begin
                    state_nxt = rxSync_r ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (sampleNow && bitCnt_r == LAST_BIT) begin
                    state_nxt = nineBitMode ? RX_NINTH : RX_STOP;
                end
            end
            RX_NINTH: begin
                if (sampleNow) begin
                    state_nxt = RX_STOP;
                end
            end
            RX_STOP: begin
                if (sampleNow) begin
                    state_nxt = RX_IDLE;
                end
            end
            default: begin
                state_nxt = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= RX_IDLE;
            half_r <= 1'b0;
            bitCnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == RX_START) begin
                half_r <= 1'b0;
                bitCnt_r <= 3'h0;
            end else if (tmrOvf) begin
                half_r <= !half_r;
                bitCnt_r <= (sampleNow && state_r == RX_DATA) ? bitCnt_r + 3'h1 : bitCnt_r;
            end
        end
    end

    // Shift register and ninth bit; in eight-bit mode the stop bit takes the ninth place
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_r <= 8'h00;
            ninth_r <= 1'b0;
        end else if (sampleNow && state_r == RX_DATA) begin
            shift_r <= {rxSync_r, shift_r[7:1]};
        end else if (sampleNow && state_r == RX_NINTH) begin
            ninth_r <= rxSync_r;
        end else if (sampleNow && state_r == RX_STOP && !nineBitMode) begin
            ninth_r <= rxSync_r;
        end
    end

    // Status outputs
    logic rxNinthBit_r;
    logic rxEvent_r;
    logic rxOverrun_r;
    wire logic stopBitNow = nineBitMode ? ninth_r : rxSync_r;
    wire logic pushWord = acceptByte && fifoReady;

    always_ff @(posedge clk) begin
        if (srst) begin
            rxNinthBit_r <= 1'b0;
            rxEvent_r <= 1'b0;
            rxOverrun_r <= 1'b0;
        end else begin
            rxNinthBit_r <= pushWord ? stopBitNow : rxNinthBit_r;
            rxEvent_r <= pushWord;
            rxOverrun_r <= (acceptByte && !fifoReady) || (rxOverrun_r && !overrunClear);
        end
    end

    assign rxNinthBit = rxNinthBit_r;
    assign rxEvent = rxEvent_r;
    assign rxOverrun = rxOverrun_r;

    // Received word buffer
    umaf_rxword_s pushData;
    assign pushData.ninth = stopBitNow;
    assign pushData.data = shift_r;

    umaf_fifo #(
        .WIDTH($bits(umaf_rxword_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .inValid(acceptByte),
        .inReady(fifoReady),
        .inData(pushData),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxWord)
    );

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_prescale_div12: assert property (
        (preWrap && !timer1DirectClockSel &&
         timer1PrescaleSel == PRE_DIV12 && $past(timer1PrescaleSel) == PRE_DIV12)
        |-> (preCnt_r == DIV12_TOP))
        else $error("div12 prescale wrapped at wrong count");
    a_prescale_ext8: assert property (
        (timer1PrescaleSel == PRE_EXT8 && !extRise && !timer1DirectClockSel) |-> !tmrTick)
        else $error("external prescale ticked without an edge");
    a_direct_clock: assert property (
        timer1DirectClockSel |-> tmrTick)
        else $error("direct clock did not tick every cycle");
    a_timer_reload: assert property (
        (tmrOvf && $stable(timerReload)) |=> (tmr_r == $past(timerReload)))
        else $error("timer did not reload on overflow");
    a_filter_drop: assert property (
        (stopSample && filterOn && !(ninth_r && addrHit)) |=> !rxEvent_r)
        else $error("filtered byte raised an event");
    a_masked_hit: assert property (
        (stopSample && filterOn && ninth_r && fifoReady &&
         ((shift_r ^ slaveAddressReg) & slaveAddressMask) == 8'h00) |=> rxEvent_r)
        else $error("masked address hit was missed");
    a_broadcast_ff: assert property (
        (stopSample && filterOn && ninth_r && fifoReady && shift_r == BROADCAST_ALL)
        |=> rxEvent_r)
        else $error("all-ones broadcast was missed");
    a_select_clear: assert property (
        (stopSample && nineBitMode && !multiprocAddrSelect && fifoReady) |=> rxEvent_r)
        else $error("data byte without select gave no event");
    a_eight_bit: assert property (
        (stopSample && !nineBitMode && fifoReady) |=> rxEvent_r)
        else $error("eight-bit byte was filtered");
    a_ninth_status: assert property (
        rxEvent_r |-> (rxNinthBit_r == $past(stopBitNow)))
        else $error("ninth bit status not captured");
    a_overrun_flag: assert property (
        (acceptByte && !fifoReady) |=> rxOverrun_r)
        else $error("overrun not flagged");
    a_prescale_div4: assert property (
        (preWrap && timer1PrescaleSel == PRE_DIV4 && $past(timer1PrescaleSel) == PRE_DIV4)
        |-> (preCnt_r == DIV4_TOP))
        else $error("div4 prescale wrapped at wrong count");
    a_prescale_div48: assert property (
        (preWrap && timer1PrescaleSel == PRE_DIV48 && $past(timer1PrescaleSel) == PRE_DIV48)
        |-> (preCnt_r == DIV48_TOP))
        else $error("div48 prescale wrapped at wrong count");
    a_timer_count: assert property (
        (tmrTick && !tmrOvf) |=> (tmr_r == $past(tmr_r) + 8'h01))
        else $error("timer did not count up by one");
    a_timer_hold: assert property (
        !tmrTick |=> $stable(tmr_r))
        else $error("timer moved without a tick");
    a_broadcast_hit: assert property (
        (stopSample && filterOn && ninth_r && fifoReady &&
         (shift_r | ~(slaveAddressReg | slaveAddressMask)) == BROADCAST_ALL) |=> rxEvent_r)
        else $error("broadcast address hit was missed");
    a_ninth_zero: assert property (
        (stopSample && filterOn && !ninth_r) |=> !rxEvent_r)
        else $error("byte with ninth bit zero raised an event");
    a_ninth_capture: assert property (
        (stopSample && nineBitMode && fifoReady && passFilter) |=>
        (rxNinthBit_r == $past(ninth_r)))
        else $error("ninth bit not copied to status");
    a_overrun_clear: assert property (
        (overrunClear && !(acceptByte && !fifoReady)) |=> !rxOverrun_r)
        else $error("overrun flag did not clear");
    a_state_onehot: assert property (
        $onehot(state_r))
        else $error("receiver state not one-hot");

    c_addr_accept: cover property (stopSample && filterOn && ninth_r && addrHit);
    c_addr_reject: cover property (stopSample && filterOn && ninth_r && !addrHit);
    c_data_byte: cover property (stopSample && nineBitMode && !multiprocAddrSelect);
    // Cover points
    c_fifo_full: cover property (acceptByte && !fifoReady);
    c_eight_bit: cover property (stopSample && !nineBitMode);
endmodule // umaf_top

//--- tb/umaf_serial_master.sv
/*
 * Master processor model that drives frames onto the shared receive line.
 * Assumes the bench calls send with the bit time in core clock cycles.
 */
module umaf_serial_master (
    // Clock
    input wire logic clk,
    // Serial line, idles high
    output logic txLine
);
    timeunit 1ns;
    timeprecision 100ps;
    initial txLine = 1'h1;
    // Start, data LSB first, optional ninth bit, stop
    task automatic send(input logic [7:0] d, input logic ninth, input logic nine,
        input int bitCyc);
        logic [10:0] bits;
        int n;
        bits = nine ? {1'h1, ninth, d, 1'h0} : {2'h3, d, 1'h0};
        n = nine ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            txLine = bits[i];
            repeat (bitCyc - 1) @(negedge clk);
        end
    endtask
endmodule // umaf_serial_master

//--- tb/tb_top.sv
/*
 * Self-checking bench for the address filter receiver.
 * Assumes the serial master model and a free-running external oscillator.
 */
module tb_top
    import umaf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic nine, sel;
        logic [7:0] addr, mask, data;
        logic ninth, acc;
    } umaf_row_s;
    typedef struct packed {
        logic direct;
        logic [1:0] pre;
        logic [7:0] rl;
        int cyc;
    } umaf_baud_s;
    logic clk, srst, rxPin, extOsc, nine, sel, direct, ovClr, rxReady;
    logic [7:0] addr, mask, reload;
    logic [1:0] pre;
    logic rxNinthBit, rxEvent, rxOverrun, rxValid;
    umaf_rxword_s rxWord;
    umaf_rxword_s popQ[$];
    int miscompares, checkCount, evCount, e0;
    umaf_row_s rows [10] = '{
        '{1'h1, 1'h1, 8'h35, 8'h0F, 8'hF5, 1'h1, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'hF3, 8'hF5, 1'h1, 1'h0},
        '{1'h1, 1'h1, 8'h35, 8'hC0, 8'hF5, 1'h1, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'hF3, 8'hFF, 1'h1, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'h0F, 8'hF5, 1'h0, 1'h0},
        '{1'h1, 1'h0, 8'h35, 8'h0F, 8'h12, 1'h0, 1'h1},
        '{1'h0, 1'h1, 8'h35, 8'h0F, 8'h12, 1'h0, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'hF3, 8'h31, 1'h1, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'h00, 8'hA5, 1'h1, 1'h1},
        '{1'h1, 1'h1, 8'h35, 8'hF3, 8'h37, 1'h1, 1'h0}
    };
    umaf_baud_s bauds [5] = '{
        '{1'h1, PRE_DIV48, 8'hF0, 32},
        '{1'h0, PRE_DIV12, 8'hF8, 192},
        '{1'h0, PRE_DIV4, 8'hF8, 64},
        '{1'h0, PRE_DIV48, 8'hFC, 384},
        '{1'h0, PRE_EXT8, 8'hF8, 640}
    };

    umaf_top u_umaf_top (.clk(clk), .srst(srst), .rxPin(rxPin), .extOscClock(extOsc),
        .nineBitMode(nine), .multiprocAddrSelect(sel), .slaveAddressReg(addr),
        .slaveAddressMask(mask), .timer1PrescaleSel(pre), .timer1DirectClockSel(direct),
        .timerReload(reload), .overrunClear(ovClr), .rxNinthBit(rxNinthBit),
        .rxEvent(rxEvent), .rxOverrun(rxOverrun), .rxValid(rxValid), .rxReady(rxReady),
        .rxWord(rxWord));
    umaf_serial_master u_umaf_serial_master (.clk(clk), .txLine(rxPin));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        extOsc = 1'h0;
        forever #12.5 extOsc = ~extOsc;
    end
    always @(posedge clk) begin
        if (rxEvent === 1'h1) evCount++;
        if (rxValid === 1'h1 && rxReady === 1'h1) popQ.push_back(rxWord);
    end

    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stopTest();
        if (miscompares == 0 && checkCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One frame, then event count, status bit and delivered word
    task automatic frame(input logic [7:0] d, input logic n9, input logic acc, input int cyc);
        e0 = evCount;
        popQ.delete();
        u_umaf_serial_master.send(d, n9, nine, cyc);
        repeat (6) @(negedge clk);
        check("event", 9'(evCount - e0), {8'h00, acc});
        check("pops", 9'(popQ.size()), {8'h00, acc});
        if (acc) begin
            check("ninth", {8'h00, rxNinthBit}, {8'h00, nine ? n9 : 1'h1});
            check("word", popQ[0], {nine ? n9 : 1'h1, d});
        end
    endtask

    initial begin
        {srst, nine, sel, direct, ovClr, rxReady} = 6'h3D;
        {addr, mask, reload, pre} = {8'h35, 8'h0F, 8'hF8, 2'h0};
        repeat (3) @(negedge clk);
        srst = 1'h0;
        @(negedge clk);
        check("reset", {5'h00, rxValid, rxEvent, rxOverrun, rxNinthBit}, 9'h000);
        repeat (300) @(negedge clk);
        foreach (rows[i]) begin
            {nine, sel, addr, mask} = {rows[i].nine, rows[i].sel, rows[i].addr, rows[i].mask};
            frame(rows[i].data, rows[i].ninth, rows[i].acc, 16);
        end
        {nine, sel, mask} = {2'h2, 8'h0F};
        foreach (bauds[i]) begin
            {direct, pre, reload} = {bauds[i].direct, bauds[i].pre, bauds[i].rl};
            repeat (bauds[i].cyc) @(negedge clk);
            frame(8'h96, 1'h0, 1'h1, bauds[i].cyc);
        end
        {direct, reload, sel, e0} = {1'h1, 8'hF8, 1'h1, evCount};
        popQ.delete();
        u_umaf_serial_master.send(8'hF5, 1'h1, 1'h1, 16);
        sel = 1'h0;
        u_umaf_serial_master.send(8'h5A, 1'h0, 1'h1, 16);
        u_umaf_serial_master.send(8'hA5, 1'h0, 1'h1, 16);
        repeat (6) @(negedge clk);
        check("b2b", 9'(evCount - e0), 9'h003);
        check("b2bword", popQ[2], 9'h0A5);
        rxReady = 1'h0;
        popQ.delete();
        for (int i = 0; i < 34; i++) u_umaf_serial_master.send(8'(i), 1'h0, 1'h1, 16);
        repeat (6) @(negedge clk);
        check("overrun", {8'h00, rxOverrun}, 9'h001);
        ovClr = 1'h1;
        @(negedge clk);
        ovClr = 1'h0;
        @(negedge clk);
        check("ovclear", {8'h00, rxOverrun}, 9'h000);
        rxReady = 1'h1;
        repeat (40) @(negedge clk);
        check("drained", 9'(popQ.size()), 9'h021);
        check("lastword", popQ[32], 9'h020);
        check("empty", {8'h00, rxValid}, 9'h000);
        rxReady = 1'h0;
        u_umaf_serial_master.send(8'h11, 1'h0, 1'h1, 16);
        repeat (6) @(negedge clk);
        check("held", {8'h00, rxValid}, 9'h001);
        srst = 1'h1;
        repeat (3) @(negedge clk);
        srst = 1'h0;
        @(negedge clk);
        check("rereset", {6'h00, rxValid, rxOverrun, rxEvent}, 9'h000);
        stopTest();
    end
    initial begin
        #300us;
        miscompares++;
        stopTest();
    end
endmodule // tb_top
